/* include/flash_seq_consts.svh */
/*
  Constants of the program flash self-programming sequencer: register
  offsets, control bit positions, reset values, unlock keys and timing.
  Assumes it is included by bare name; holds definitions only.
*/
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

`define REG_ADDR_LOW      3'h0
`define REG_ADDR_HIGH     3'h1
`define REG_DATA_LOW      3'h2
`define REG_DATA_HIGH     3'h3
`define REG_NVM_CONTROL   3'h4
`define REG_NVM_UNLOCK    3'h5

`define CTL_START         0
`define CTL_WRITE_ENABLE_BIT          2
`define CTL_ERASE         4
`define CTL_LOAD_LATCHES_ONLY          5
`define CTL_CONFIG_SPACE_SELECT          6
`define CTL_PGD           7
`define CTL_RESET         8'h00

`define UNLOCK_KEY1       8'h55
`define UNLOCK_KEY2       8'hAA

`define LATCH_COUNT       32
`define LATCH_IDX_W       5
`define WORD_W            14
`define LATCH_ERASED      14'h3FFF
`define LAST_LATCH        5'h1F

`define CLK_FREQ_MHZ      100
`define SETUP_CYCLES      2
`define ERASE_TIME_US     2000
`define PROG_TIME_US      2000

`endif

/* include/flash_seq_pkg.sv */
/*
  Types of the program flash sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_seq_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_setup,
    st_erase,
    st_push,
    st_prog
  } seq_state_t;

  typedef enum logic [1:0] {
    ulk_idle,
    ulk_key1,
    ulk_armed
  } unlock_state_t;

endpackage

/* include/latch_bus_if.sv */
/*
  Carrier between the sequencer and its write latch bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`include "flash_seq_consts.svh"

interface latch_bus_if;
  logic                      load;
  logic [`LATCH_IDX_W-1:0]   load_idx;
  logic [`WORD_W-1:0]        load_data;
  logic                      clear_all;
  logic [`LATCH_IDX_W-1:0]   rd_idx;
  logic [`WORD_W-1:0]        rd_data;

  modport seq (
    output load, load_idx, load_data, clear_all, rd_idx,
    input  rd_data
  );
  modport bank (
    input  load, load_idx, load_data, clear_all, rd_idx,
    output rd_data
  );
endinterface

/* verilog/write_latch_bank.sv */
/*
  Block of flash write latches in flip-flops, indexed by the low address.
  Assumes the sequencer drives at most one of load or clear per cycle.
*/
`timescale 1ns/1ns
`include "flash_seq_consts.svh"

module write_latch_bank
  import flash_seq_pkg::*;
(
  // Clock, reset, enable
  input  wire logic  mclk_in,
  input  wire logic  rstn_in,
  input  wire logic  ce_in,
  // Sequencer side
  latch_bus_if.bank  lb
);

  logic [`WORD_W-1:0] latch_reg  [`LATCH_COUNT];
  logic [`WORD_W-1:0] latch_next [`LATCH_COUNT];

  always_comb begin
    for (int i = 0; i < `LATCH_COUNT; i++) begin
      latch_next[i] = latch_reg[i];
      if (lb.clear_all) begin
        latch_next[i] = `LATCH_ERASED;
      end else if (lb.load && lb.load_idx == `LATCH_IDX_W'(i)) begin
        latch_next[i] = lb.load_data;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < `LATCH_COUNT; i++) begin
        latch_reg[i] <= `LATCH_ERASED;
      end
    end else if (ce_in) begin
      for (int i = 0; i < `LATCH_COUNT; i++) begin
        latch_reg[i] <= latch_next[i];
      end
    end
  end

  assign lb.rd_data = latch_reg[lb.rd_idx];

endmodule // write_latch_bank

/* verilog/flash_sequencer.sv */
/*
  Program flash self-programming sequencer: unlock check, row erase,
  latch loads and block programming, with a core stall output.
  Assumes the register port is driven by the core on the same clock and
  that the flash array outside takes one word per flash_word_wr_out pulse.
*/
`timescale 1ns/1ns
`include "flash_seq_consts.svh"

module flash_sequencer
  import flash_seq_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = `ERASE_TIME_US * `CLK_FREQ_MHZ,
  parameter int unsigned PROG_CYCLES  = `PROG_TIME_US * `CLK_FREQ_MHZ
) (
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  // Register port
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // Core control
  output logic             core_stall_out,
  // Flash array
  output logic      [14:0] flash_addr_out,
  output logic      [13:0] flash_data_out,
  output logic             flash_word_wr_out,
  output logic             flash_row_erase_out,
  output logic             flash_prog_out
);

  localparam logic [17:0] SETUP_LOAD = 18'(`SETUP_CYCLES - 1);
  localparam logic [17:0] ERASE_LOAD = 18'(ERASE_CYCLES - 1);
  localparam logic [17:0] PROG_LOAD  = 18'(PROG_CYCLES - 1);

  latch_bus_if lb ();

  write_latch_bank u_bank (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .ce_in   (ce_in),
    .lb      (lb.bank)
  );

  seq_state_t                state_reg,   state_next;
  unlock_state_t             unlock_reg,  unlock_next;
  logic [7:0]                addr_low_reg,  addr_low_next;
  logic [6:0]                addr_high_reg, addr_high_next;
  logic [7:0]                data_low_reg,  data_low_next;
  logic [5:0]                data_high_reg, data_high_next;
  logic [7:0]                ctrl_reg,    ctrl_next;
  logic [17:0]               cnt_reg,     cnt_next;
  logic [`LATCH_IDX_W-1:0]   push_idx_reg, push_idx_next;
  logic [7:0]                rdata_reg,   rdata_next;
  logic                      stall_reg,   stall_next;
  logic [14:0]               faddr_reg,   faddr_next;
  logic [13:0]               fdata_reg,   fdata_next;
  logic                      fwr_reg,     fwr_next;
  logic                      ferase_reg,  ferase_next;
  logic                      fprog_reg,   fprog_next;
  logic                      start;
  logic                      ctrl_wr;

  assign ctrl_wr = reg_wr_in && reg_addr_in == `REG_NVM_CONTROL;

  // Start needs the armed unlock, enable, program space and not config
  assign start = (state_reg == st_idle) && ctrl_wr
                 && reg_wdata_in[`CTL_START]
                 && reg_wdata_in[`CTL_WRITE_ENABLE_BIT]
                 && reg_wdata_in[`CTL_PGD]
                 && !reg_wdata_in[`CTL_CONFIG_SPACE_SELECT]
                 && unlock_reg == ulk_armed;

  always_comb begin
    state_next     = state_reg;
    unlock_next    = unlock_reg;
    addr_low_next  = addr_low_reg;
    addr_high_next = addr_high_reg;
    data_low_next  = data_low_reg;
    data_high_next = data_high_reg;
    ctrl_next      = ctrl_reg;
    cnt_next       = cnt_reg;
    push_idx_next  = push_idx_reg;
    rdata_next     = 8'h00;
    stall_next     = stall_reg;
    faddr_next     = faddr_reg;
    fdata_next     = fdata_reg;
    fwr_next       = 1'b0;
    ferase_next    = ferase_reg;
    fprog_next     = fprog_reg;
    lb.load        = 1'b0;
    lb.load_idx    = addr_low_reg[`LATCH_IDX_W-1:0];
    lb.load_data   = {data_high_reg, data_low_reg};
    lb.clear_all   = 1'b0;
    lb.rd_idx      = push_idx_reg;

    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `REG_ADDR_LOW:    rdata_next = addr_low_reg;
        `REG_ADDR_HIGH:   rdata_next = {1'b0, addr_high_reg};
        `REG_DATA_LOW:    rdata_next = data_low_reg;
        `REG_DATA_HIGH:   rdata_next = {2'b00, data_high_reg};
        `REG_NVM_CONTROL: rdata_next = ctrl_reg;
        default:          rdata_next = 8'h00;
      endcase
    end

    // Any write other than the next key breaks the unlock
    if (reg_wr_in) begin
      unlock_next = ulk_idle;
      if (reg_addr_in == `REG_NVM_UNLOCK) begin
        if (reg_wdata_in == `UNLOCK_KEY1) begin
          unlock_next = ulk_key1;
        end else if (reg_wdata_in == `UNLOCK_KEY2
                     && unlock_reg == ulk_key1) begin
          unlock_next = ulk_armed;
        end
      end
    end

    // Address, data and control writes are dropped while an operation is in flight; unlock keys still count
    if (reg_wr_in && state_reg == st_idle) begin
      unique case (reg_addr_in)
        `REG_ADDR_LOW:    addr_low_next  = reg_wdata_in;
        `REG_ADDR_HIGH:   addr_high_next = reg_wdata_in[6:0];
        `REG_DATA_LOW:    data_low_next  = reg_wdata_in;
        `REG_DATA_HIGH:   data_high_next = reg_wdata_in[5:0];
        `REG_NVM_CONTROL: begin
          ctrl_next = reg_wdata_in;
          ctrl_next[`CTL_START] = start;
          ctrl_next[1] = 1'b0;
          ctrl_next[3] = 1'b0;
        end
        default: ;
      endcase
    end

    unique case (state_reg)
      st_idle: begin
        if (start) begin
          state_next = st_setup;
          cnt_next   = SETUP_LOAD;
          if (!reg_wdata_in[`CTL_ERASE]) begin
            lb.load = 1'b1;
          end
        end
      end
      st_setup: begin
        cnt_next = cnt_reg - 18'h00001;
        if (cnt_reg == 18'h00000) begin
          if (ctrl_reg[`CTL_ERASE]) begin
            // Whole row only: low index bits forced to zero
            state_next  = st_erase;
            cnt_next    = ERASE_LOAD;
            faddr_next  = {addr_high_reg, addr_low_reg[7:5], 5'h00};
            ferase_next = 1'b1;
            stall_next  = 1'b1;
          end else if (ctrl_reg[`CTL_LOAD_LATCHES_ONLY]) begin
            state_next = st_idle;
            ctrl_next[`CTL_START] = 1'b0;
          end else begin
            state_next    = st_push;
            push_idx_next = '0;
            stall_next    = 1'b1;
          end
        end
      end
      st_erase: begin
        cnt_next = cnt_reg - 18'h00001;
        if (cnt_reg == 18'h00000) begin
          state_next  = st_idle;
          ferase_next = 1'b0;
          stall_next  = 1'b0;
          ctrl_next[`CTL_ERASE] = 1'b0;
          ctrl_next[`CTL_START] = 1'b0;
        end
      end
      st_push: begin
        // Every latch goes out, loaded or not, inside one aligned block
        faddr_next = {addr_high_reg, addr_low_reg[7:5], push_idx_reg};
        fdata_next    = lb.rd_data;
        fwr_next      = 1'b1;
        push_idx_next = push_idx_reg + 5'h01;
        if (push_idx_reg == `LAST_LATCH) begin
          state_next = st_prog;
          cnt_next   = PROG_LOAD;
          fprog_next = 1'b1;
        end
      end
      st_prog: begin
        cnt_next = cnt_reg - 18'h00001;
        if (cnt_reg == 18'h00000) begin
          state_next   = st_idle;
          fprog_next   = 1'b0;
          stall_next   = 1'b0;
          lb.clear_all = 1'b1;
          ctrl_next[`CTL_START] = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg     <= st_idle;
      unlock_reg    <= ulk_idle;
      addr_low_reg  <= 8'h00;
      addr_high_reg <= 7'h00;
      data_low_reg  <= 8'h00;
      data_high_reg <= 6'h00;
      ctrl_reg      <= `CTL_RESET;
      cnt_reg       <= 18'h00000;
      push_idx_reg  <= 5'h00;
      rdata_reg     <= 8'h00;
      stall_reg     <= 1'b0;
      faddr_reg     <= 15'h0000;
      fdata_reg     <= 14'h0000;
      fwr_reg       <= 1'b0;
      ferase_reg    <= 1'b0;
      fprog_reg     <= 1'b0;
    end else if (ce_in) begin
      state_reg     <= state_next;
      unlock_reg    <= unlock_next;
      addr_low_reg  <= addr_low_next;
      addr_high_reg <= addr_high_next;
      data_low_reg  <= data_low_next;
      data_high_reg <= data_high_next;
      ctrl_reg      <= ctrl_next;
      cnt_reg       <= cnt_next;
      push_idx_reg  <= push_idx_next;
      rdata_reg     <= rdata_next;
      stall_reg     <= stall_next;
      faddr_reg     <= faddr_next;
      fdata_reg     <= fdata_next;
      fwr_reg       <= fwr_next;
      ferase_reg    <= ferase_next;
      fprog_reg     <= fprog_next;
    end
  end

  assign reg_rdata_out       = rdata_reg;
  assign core_stall_out      = stall_reg;
  assign flash_addr_out      = faddr_reg;
  assign flash_data_out      = fdata_reg;
  assign flash_word_wr_out   = fwr_reg;
  assign flash_row_erase_out = ferase_reg;
  assign flash_prog_out      = fprog_reg;

endmodule // flash_sequencer

/* sim/flash_seq_checker.sv */
/* Port assertions for the flash sequencer top.
   Assumes a bind onto flash_sequencer with its short sim counts. */
`timescale 1ns/1ns
module flash_seq_checker #(
  parameter int unsigned ERASE_CYCLES = 20,
  parameter int unsigned PROG_CYCLES  = 20
) (
  // Clock, reset, enable
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  // Register port
  input wire logic [2:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  // Core and flash
  input wire logic        core_stall_out,
  input wire logic [14:0] flash_addr_out,
  input wire logic [13:0] flash_data_out,
  input wire logic        flash_word_wr_out,
  input wire logic        flash_row_erase_out,
  input wire logic        flash_prog_out
);
  int unsigned run_reg;
  int unsigned run_next;
  logic [5:0]  word_reg;
  logic [5:0]  word_next;
  always_comb begin
    run_next  = (flash_row_erase_out | flash_prog_out) ? run_reg + 1 : 0;
    word_next = core_stall_out ? word_reg + {5'h00, flash_word_wr_out} : 6'h00;
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_reg  <= 0;
      word_reg <= 6'h00;
    end else if (ce_in) begin
      run_reg  <= run_next;
      word_reg <= word_next;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  AST_ERASE_STALL: assert property (flash_row_erase_out |-> core_stall_out)
    else $error("erase without core stall");
  AST_PROG_HALT: assert property ((flash_prog_out || flash_word_wr_out) |->
    core_stall_out && !flash_row_erase_out) else $error("program phase bad");
  AST_ERASE_LEN: assert property ($fell(flash_row_erase_out) |->
    run_reg == ERASE_CYCLES) else $error("erase length wrong");
  AST_PROG_LEN: assert property ($fell(flash_prog_out) |->
    run_reg == PROG_CYCLES) else $error("program length wrong");
  AST_ROW_ALIGN: assert property (flash_row_erase_out |->
    flash_addr_out[4:0] == 5'h00) else $error("erase row misaligned");
  // Last of the 32 words goes out in the cycle that program rises
  AST_WORD_COUNT: assert property ($rose(flash_prog_out) |->
    word_reg == 6'h1F && flash_word_wr_out) else $error("word count");
  AST_WORD_SEQ: assert property (flash_word_wr_out && $past(flash_word_wr_out)
    |-> flash_addr_out == $past(flash_addr_out) + 15'h0001 &&
    flash_addr_out[4:0] != 5'h00) else $error("word address step wrong");
  AST_SETUP: assert property ($rose(core_stall_out) |-> $past(reg_wr_in, 3)
    && $past(reg_addr_in, 3) == 3'h4) else $error("setup gap wrong");
  AST_RESUME: assert property ($fell(core_stall_out) |->
    $past(flash_row_erase_out) || $past(flash_prog_out))
    else $error("stall ended early");
  AST_RD_ZERO: assert property ($past(reg_rd_in) && $past(reg_addr_in) >= 3'h5
    |-> reg_rdata_out == 8'h00) else $error("unlock or hole read nonzero");
  cover property ($rose(flash_row_erase_out));
  cover property ($rose(flash_prog_out));
  cover property ($fell(core_stall_out));
endmodule // flash_seq_checker

/* sim/core_model.sv */
/* Core-side firmware model: register accesses, unlock, start, wait.
   Assumes the sequencer register port on the same clock. */
`timescale 1ns/1ns
module core_model (
  // Clock and stall
  input  wire logic       mclk_in,
  input  wire logic       stall_in,
  // Register port
  output logic      [2:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial begin
    addr_out  = 3'h0;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end
  // One access per edge; strobes drop only at the next call
  task automatic acc(input logic w, input logic r, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge mclk_in);
    wr_out    <= w;
    rd_out    <= r;
    addr_out  <= a;
    wdata_out <= d;
  endtask
  task automatic nop();
    acc(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  // Keys back to back so nothing can slip between them
  task automatic start(input logic [7:0] ctl);
    acc(1'b1, 1'b0, 3'h5, 8'h55);
    acc(1'b1, 1'b0, 3'h5, 8'hAA);
    acc(1'b1, 1'b0, 3'h4, ctl);
    nop();
    nop();
  endtask
  // Stalled core issues nothing
  task automatic finish_op();
    repeat (4) nop();
    while (stall_in) nop();
    nop();
  endtask
endmodule // core_model

/* sim/tb.sv */
/* Self-checking bench for the flash sequencer.
   Assumes core_model drives the register port; short erase/program. */
`timescale 1ns/1ns
module tb;
  logic        mclk_in;
  logic        rstn_in;
  logic        ce_in;
  logic [2:0]  ra;
  logic [7:0]  rw;
  logic [7:0]  rq;
  logic        wr;
  logic        rd;
  logic        stall;
  logic        word_wr;
  logic        erase;
  logic        prog;
  logic [14:0] fa;
  logic [13:0] fd;
  logic [14:0] erow;
  logic        rd_seen = 1'b0;
  logic [7:0]  rexp_q[$];
  logic [7:0]  rmsk_q[$];
  logic [28:0] wexp_q[$];
  logic [13:0] lat[32];
  logic [31:0] r;
  logic [7:0]  ah;
  logic [7:0]  base;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          seed;
  initial mclk_in = 1'b0;
  always #5 mclk_in = ~mclk_in;
  flash_sequencer #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) uut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .reg_addr_in(ra), .reg_wdata_in(rw), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rq), .core_stall_out(stall), .flash_addr_out(fa),
    .flash_data_out(fd), .flash_word_wr_out(word_wr),
    .flash_row_erase_out(erase), .flash_prog_out(prog));
  core_model core (.mclk_in(mclk_in), .stall_in(stall), .addr_out(ra),
    .wdata_out(rw), .wr_out(wr), .rd_out(rd));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("TB counts: compares=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rd_exp(input logic [2:0] a, input logic [7:0] e, m);
    rexp_q.push_back(e);
    rmsk_q.push_back(m);
    core.acc(1'b0, 1'b1, a, 8'h00);
    core.nop();
  endtask
  // Watcher: oldest note against each result seen
  always @(posedge mclk_in) begin
    rd_seen <= rd;
    if (rd_seen) check({24'h0, rq & rmsk_q.pop_front()}, {24'h0, rexp_q.pop_front()});
    if (erase) check({17'h0, fa}, {17'h0, erow});
    if (word_wr && wexp_q.size() == 0) check(32'h1, 32'h0);
    else if (word_wr) check({3'h0, fa, fd}, {3'h0, wexp_q.pop_front()});
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    seed = 32'hd8c67c71;
    rstn_in = 1'b0;
    ce_in = 1'b1;
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd_exp(3'h4, 8'h00, 8'hFF);
    rd_exp(3'h5, 8'h00, 8'hFF);
    rd_exp(3'h7, 8'h00, 8'hFF);
    $display("T1 reset reads done");
    core.acc(1'b1, 1'b0, 3'h5, 8'h55);
    core.acc(1'b1, 1'b0, 3'h0, 8'h12);
    core.acc(1'b1, 1'b0, 3'h5, 8'hAA);
    core.acc(1'b1, 1'b0, 3'h4, 8'h95);
    core.finish_op();
    rd_exp(3'h4, 8'h00, 8'h01);
    foreach (lat[i]) lat[i] = 14'h3FFF;
    for (int k = 0; k < 3; k++) begin
      core.start(k == 0 ? 8'h91 : k == 1 ? 8'hD5 : 8'h15);
      core.finish_op();
      rd_exp(3'h4, 8'h00, 8'h01);
    end
    $display("T2 refused starts done");
    for (int k = 0; k < 2; k++) begin
      r = $random(seed);
      erow = {r[14:5], 5'h00};
      core.acc(1'b1, 1'b0, 3'h0, r[7:0]);
      core.acc(1'b1, 1'b0, 3'h1, {1'b0, r[14:8]});
      core.start(8'h95);
      core.finish_op();
      rd_exp(3'h4, 8'h00, 8'h11);
    end
    $display("T3 row erase done");
    for (int k = 0; k < 2; k++) begin
      r = $random(seed);
      ah = {1'b0, r[6:0]};
      base = {r[10:8], 5'h00};
      core.acc(1'b1, 1'b0, 3'h1, ah);
      for (int i = 0; i < 32; i++) begin
        r = $random(seed);
        if (i == 31 || (k == 0 && r[20])) begin
          lat[i] = r[13:0];
          core.acc(1'b1, 1'b0, 3'h0, base | 8'(i));
          core.acc(1'b1, 1'b0, 3'h2, r[7:0]);
          core.acc(1'b1, 1'b0, 3'h3, {2'b00, r[13:8]});
          if (i < 31) core.start(8'hA5);
          if (i < 31) core.finish_op();
        end
      end
      for (int i = 0; i < 32; i++)
        wexp_q.push_back({ah[6:0], base[7:5], 5'(i), lat[i]});
      core.start(8'h85);
      core.finish_op();
      rd_exp(3'h4, 8'h00, 8'h01);
      foreach (lat[i]) lat[i] = 14'h3FFF;
    end
    check(32'(wexp_q.size()), 32'h0);
    $display("T4 block writes done");
    // Write with enable low must leave the address untouched
    @(posedge mclk_in);
    ce_in <= 1'b0;
    core.acc(1'b1, 1'b0, 3'h0, ~(base | 8'h1F));
    core.nop();
    ce_in <= 1'b1;
    rd_exp(3'h0, base | 8'h1F, 8'hFF);
    // Let the watcher take the last read before closing
    repeat (2) @(posedge mclk_in);
    $display("T5 clock enable freeze done");
    final_report();
  end
endmodule // tb
bind flash_sequencer flash_seq_checker #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)) chk (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .core_stall_out(core_stall_out),
  .flash_addr_out(flash_addr_out), .flash_data_out(flash_data_out),
  .flash_word_wr_out(flash_word_wr_out),
  .flash_row_erase_out(flash_row_erase_out),
  .flash_prog_out(flash_prog_out));
